// file: logic/ofd_decoder.v
// operand field decoder top
// How it works
// - no size flag: codes pick full registers
// - size flag zero: low/high byte registers
// - form 11 makes locator a register
// - register selector from three sources
// - two-bit segment field to four segments
// - three-bit segment field to six segments
// - 32-bit mode locator 100 needs index byte
// - index byte fields set 32-bit address
// - middle bits are opcode or register
// - address size picks 16/32-bit table
// - fixed-addressing instructions skip form byte
// - 16-bit form 00 base combos, segments
// - forms 01/10 add disp8/disp16 (disp8/disp32 with 32-bit addresses)
// - size flag picks byte or full
// - prefixes invert size for one instruction
`timescale 1ns/1ps
`include "ofd_regs.vh"
module ofd_decoder (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_valid,
  input wire i_default32,
  input wire i_opsize_prefix,
  input wire i_addrsize_prefix,
  input wire i_has_size,
  input wire i_size_flag,
  input wire [2:0] i_opcode_reg,
  input wire [1:0] i_reg_src,
  input wire i_fixed_addr,
  input wire i_middle_is_reg,
  input wire [7:0] i_form_byte,
  input wire [7:0] i_index_byte,
  input wire [1:0] i_segment_sel_narrow,
  input wire [2:0] i_segment_sel_wide,
  input wire i_seg_wide,
  output reg o_valid,
  output reg [4:0] o_reg_sel,
  output reg o_mem_operand,
  output reg [2:0] o_segment,
  output reg [2:0] o_default_seg,
  output reg [2:0] o_ea_base,
  output reg [2:0] o_ea_index,
  output reg [1:0] o_ea_scale,
  output reg o_ea_index_en,
  output reg [1:0] o_disp_size,
  output reg o_index_byte_present,
  output reg [2:0] o_opcode_ext,
  output reg o_addr32,
  output reg o_invalid_seg
);
  // ==========================================
  // sizes and fields
  wire op32;
  wire addr32;
  wire [1:0] form;
  wire [2:0] middle;
  wire [2:0] locator;
  reg [2:0] reg_code;
  wire [4:0] map_sel;
  assign op32 = i_default32 ^ i_opsize_prefix;
  assign addr32 = i_default32 ^ i_addrsize_prefix;
  assign form = i_form_byte[7:6];
  assign middle = i_form_byte[5:3];
  assign locator = i_form_byte[2:0];
  always @* begin
    case (i_reg_src)
      `OFD_SRC_OPCODE: reg_code = i_opcode_reg;
      `OFD_SRC_MIDDLE: reg_code = middle;
      `OFD_SRC_LOCATOR: reg_code = locator;
      default: reg_code = i_opcode_reg;
    endcase
  end
  ofd_reg_map u_map (
    .i_code(reg_code),
    .i_has_size(i_has_size),
    .i_size_flag(i_size_flag),
    .i_op32(op32),
    .o_sel(map_sel)
  );
  // ==========================================
  // segment and address decode
  reg [2:0] seg_next;
  reg bad_seg_next;
  reg mem_next;
  reg [4:0] reg_sel_next;
  reg [2:0] dseg_next;
  reg [2:0] base_next;
  reg [2:0] index_next;
  reg [1:0] scale_next;
  reg index_en_next;
  reg [1:0] disp_next;
  reg sib_next;
  always @* begin
    bad_seg_next = 1'b0;
    if (i_seg_wide) begin
      seg_next = i_segment_sel_wide;
      if (i_segment_sel_wide[2] && i_segment_sel_wide[1]) begin
        seg_next = `OFD_SEG_DS;
        bad_seg_next = 1'b1;
      end
    end else begin
      seg_next = {1'b0, i_segment_sel_narrow};
    end
  end
  always @* begin
    mem_next = 1'b0;
    reg_sel_next = map_sel;
    dseg_next = `OFD_SEG_DS;
    base_next = `OFD_AREG_NONE;
    index_next = `OFD_AREG_NONE;
    scale_next = 2'h0;
    index_en_next = 1'b0;
    disp_next = `OFD_DISP_NONE;
    sib_next = 1'b0;
    if (i_fixed_addr) begin
      mem_next = 1'b0;
    end else if (form == `OFD_FORM_REG) begin
      mem_next = 1'b0;
    end else if (addr32) begin
      mem_next = 1'b1;
      base_next = locator;
      if (form == `OFD_FORM_DISP8) begin
        disp_next = `OFD_DISP_8;
      end else if (form == `OFD_FORM_DISPW) begin
        disp_next = `OFD_DISP_32;
      end
      if (locator == `OFD_LOC_SIB) begin
        sib_next = 1'b1;
        base_next = i_index_byte[2:0];
        index_next = i_index_byte[5:3];
        index_en_next = (i_index_byte[5:3] != `OFD_LOC_SIB);
        scale_next = i_index_byte[7:6];
        if (base_next == `OFD_AREG_FRAME && form == `OFD_FORM_NODISP) begin
          disp_next = `OFD_DISP_32;
          base_next = `OFD_AREG_NONE;
        end else if (base_next == `OFD_LOC_SIB || base_next == `OFD_AREG_FRAME) begin
          dseg_next = `OFD_SEG_SS;
        end
      end else if (locator == `OFD_LOC_DIRECT32) begin
        if (form == `OFD_FORM_NODISP) begin
          disp_next = `OFD_DISP_32;
          base_next = `OFD_AREG_NONE;
        end else begin
          dseg_next = `OFD_SEG_SS;
        end
      end
    end else begin
      mem_next = 1'b1;
      case (locator)
        3'h0: begin
          base_next = `OFD_AREG_BASE;
          index_next = `OFD_AREG_SRC;
        end
        3'h1: begin
          base_next = `OFD_AREG_BASE;
          index_next = `OFD_AREG_DST;
        end
        3'h2: begin
          base_next = `OFD_AREG_FRAME;
          index_next = `OFD_AREG_SRC;
        end
        3'h3: begin
          base_next = `OFD_AREG_FRAME;
          index_next = `OFD_AREG_DST;
        end
        3'h4: base_next = `OFD_AREG_SRC;
        3'h5: base_next = `OFD_AREG_DST;
        3'h6: base_next = `OFD_AREG_FRAME;
        default: base_next = `OFD_AREG_BASE;
      endcase
      index_en_next = (locator[2] == 1'b0);
      if (base_next == `OFD_AREG_FRAME) begin
        dseg_next = `OFD_SEG_SS;
      end
      if (form == `OFD_FORM_DISP8) begin
        disp_next = `OFD_DISP_8;
      end else if (form == `OFD_FORM_DISPW) begin
        disp_next = `OFD_DISP_16;
      end else if (locator == `OFD_LOC_DIRECT16) begin
        disp_next = `OFD_DISP_16;
        base_next = `OFD_AREG_NONE;
        dseg_next = `OFD_SEG_DS;
      end
    end
    // middle bits as register or opcode
    if (i_reg_src == `OFD_SRC_LOCATOR && mem_next) begin
      reg_sel_next = {`OFD_RSIZE_NONE, 3'h0};
    end else if (i_reg_src == `OFD_SRC_MIDDLE && !i_middle_is_reg) begin
      reg_sel_next = {`OFD_RSIZE_NONE, 3'h0};
    end
  end
  // ==========================================
  // output registers
  // registered outputs, reset idle
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_reg_sel <= {`OFD_RSIZE_NONE, 3'h0};
      o_mem_operand <= 1'b0;
      o_segment <= `OFD_SEG_DS;
      o_default_seg <= `OFD_SEG_DS;
      o_ea_base <= `OFD_AREG_NONE;
      o_ea_index <= `OFD_AREG_NONE;
      o_ea_scale <= 2'h0;
      o_ea_index_en <= 1'b0;
      o_disp_size <= `OFD_DISP_NONE;
      o_index_byte_present <= 1'b0;
      o_opcode_ext <= 3'h0;
      o_addr32 <= 1'b0;
      o_invalid_seg <= 1'b0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_reg_sel <= reg_sel_next;
        o_mem_operand <= mem_next;
        o_segment <= seg_next;
        o_default_seg <= dseg_next;
        o_ea_base <= base_next;
        o_ea_index <= index_next;
        o_ea_scale <= scale_next;
        o_ea_index_en <= index_en_next;
        o_disp_size <= disp_next;
        o_index_byte_present <= sib_next;
        o_opcode_ext <= middle;
        o_addr32 <= addr32;
        o_invalid_seg <= bad_seg_next;
      end
    end
  end
endmodule

// file: logic/ofd_reg_map.v
// general register selector decode
`timescale 1ns/1ps
`include "ofd_regs.vh"
module ofd_reg_map (
  input wire [2:0] i_code,
  input wire i_has_size,
  input wire i_size_flag,
  input wire i_op32,
  output reg [4:0] o_sel
);
  always @* begin
    if (i_has_size && !i_size_flag) begin
      o_sel = {`OFD_RSIZE_8, i_code};
    end else if (i_op32) begin
      o_sel = {`OFD_RSIZE_32, i_code};
    end else begin
      o_sel = {`OFD_RSIZE_16, i_code};
    end
  end
endmodule

// file: logic/ofd_regs.vh
// constants for the operand field decoder
`ifndef OFD_REGS_VH
`define OFD_REGS_VH
// register select encoding: {size[1:0], code[2:0]}
`define OFD_RSIZE_8 2'h0
`define OFD_RSIZE_16 2'h1
`define OFD_RSIZE_32 2'h2
`define OFD_RSIZE_NONE 2'h3
// segment encoding
`define OFD_SEG_ES 3'h0
`define OFD_SEG_CS 3'h1
`define OFD_SEG_SS 3'h2
`define OFD_SEG_DS 3'h3
`define OFD_SEG_FS 3'h4
`define OFD_SEG_GS 3'h5
// register source select
`define OFD_SRC_OPCODE 2'h0
`define OFD_SRC_MIDDLE 2'h1
`define OFD_SRC_LOCATOR 2'h2
// addressing form values
`define OFD_FORM_NODISP 2'h0
`define OFD_FORM_DISP8 2'h1
`define OFD_FORM_DISPW 2'h2
`define OFD_FORM_REG 2'h3
// displacement size codes
`define OFD_DISP_NONE 2'h0
`define OFD_DISP_8 2'h1
`define OFD_DISP_16 2'h2
`define OFD_DISP_32 2'h3
// address component codes (16-bit mode) and locator codes
`define OFD_AREG_NONE 3'h0
`define OFD_AREG_BASE 3'h3
`define OFD_AREG_FRAME 3'h5
`define OFD_AREG_SRC 3'h6
`define OFD_AREG_DST 3'h7
`define OFD_LOC_SIB 3'h4
`define OFD_LOC_DIRECT16 3'h6
`define OFD_LOC_DIRECT32 3'h5
`endif

// file: sim/ofd_decoder_bench.sv
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
module ofd_decoder_bench;
  logic i_core_clk = '0, i_rst = '1, i_valid = '0, i_default32 = '0, i_opsize_prefix = '0;
  logic i_addrsize_prefix = '0, i_has_size = '0, i_size_flag = '0, i_fixed_addr = '0;
  logic i_middle_is_reg = '1, i_seg_wide = '0, allow_bad = '0;
  logic [2:0] i_opcode_reg = '0, i_segment_sel_wide, o_segment, o_default_seg, o_ea_base;
  logic [2:0] o_ea_index, o_opcode_ext, c, loc, b;
  logic [8:0] a, eaq[$];
  logic [1:0] i_reg_src = '0, i_segment_sel_narrow = '0, o_ea_scale, o_disp_size, f;
  logic [7:0] i_form_byte, i_index_byte;
  logic o_valid, o_mem_operand, o_ea_index_en, o_index_byte_present, o_addr32, o_invalid_seg;
  logic [4:0] o_reg_sel;
  logic [19:0] e, m;
  logic [39:0] n, exq[$];
  logic [31:0] r;
  integer seed = 32'h687d3b3d, miscompares = 0, checks = 0;
  always #2 i_core_clk = ~i_core_clk;
  ofd_decoder dut_u (.*);
  ofd_fetch_model fetch_u (.i_core_clk, .i_advance(i_valid), .i_allow_bad(allow_bad),
    .o_form_byte(i_form_byte), .o_index_byte(i_index_byte), .o_seg_wide(i_segment_sel_wide));
  task automatic check(input string what, input logic [19:0] exp, got, msk);
    checks++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp & msk, got & msk);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(input int cycles);
    i_rst = 1'h1;
    repeat (cycles) @(negedge i_core_clk);
    i_rst = 1'h0;
    check("reset", 20'hc3, {11'h0, o_valid, o_reg_sel, o_segment}, 20'h1ff);
  endtask
  task automatic issue(input logic fx, input logic go);
    @(negedge i_core_clk);
    r = $random(seed);
    {i_size_flag, i_has_size, i_addrsize_prefix, i_opsize_prefix, i_default32} = r[4:0];
    i_middle_is_reg = r[15];
    {i_reg_src, i_opcode_reg} = r[9:5];
    i_segment_sel_narrow = r[11:10];
    i_seg_wide = r[12] | allow_bad;
    i_fixed_addr = fx;
    i_valid = go & (r[13] | r[14]);
    f = i_form_byte[7:6];
    loc = i_form_byte[2:0];
    c = i_reg_src == 2'h1 ? i_form_byte[5:3] : i_reg_src == 2'h2 ? loc : r[7:5];
    e[19:15] = {(r[3] & !r[4]) ? 2'h0 : (r[0] ^ r[1]) ? 2'h2 : 2'h1, c};
    if (i_reg_src == 2'h2 && f != 2'h3 && !fx) e[19:15] = 5'h18;
    if (i_reg_src == 2'h1 && !r[15]) e[19:15] = 5'h18;
    e[14:11] = !i_seg_wide ? {1'h0, r[11:10], 1'h0} :
      i_segment_sel_wide > 3'h5 ? 4'h7 : {i_segment_sel_wide, 1'h0};
    e[10:9] = 2'h0;
    e[8] = !fx && (r[0] ^ r[2]) && loc == 3'h4 && f != 2'h3;
    e[7:5] = 3'h3;
    e[4:0] = {r[0] ^ r[2], i_form_byte[5:3], !fx && f != 2'h3};
    m = 20'hfffff;
    a = 9'h0;
    b = (loc == 3'h4) ? i_index_byte[2:0] : loc;
    if (!fx && f != 2'h3 && (r[0] ^ r[2])) begin
      a[8:6] = (b == 3'h5 && f == 2'h0) ? 3'h0 : b;
      if (loc == 3'h4) a[5:0] = {i_index_byte[5:3], i_index_byte[7:6], i_index_byte[5:3] != 3'h4};
      e[10:9] = f == 2'h1 ? 2'h1 : (f == 2'h2 || b == 3'h5) ? 2'h3 : 2'h0;
      if (b == 3'h4 || (b == 3'h5 && f != 2'h0)) e[7:5] = 3'h2;
    end else if (!fx && f != 2'h3) begin
      case (loc)
        3'h0, 3'h1, 3'h7: a[8:6] = 3'h3;
        3'h2, 3'h3: a[8:6] = 3'h5;
        3'h4: a[8:6] = 3'h6;
        3'h5: a[8:6] = 3'h7;
        default: a[8:6] = f == 2'h0 ? 3'h0 : 3'h5;
      endcase
      a[5:3] = loc[2] ? 3'h0 : {2'h3, loc[0]};
      a[0] = !loc[2];
      e[10:9] = (f == 2'h0 && loc == 3'h6) ? 2'h2 : f;
      if (loc == 3'h2 || loc == 3'h3 || (loc == 3'h6 && f != 2'h0)) e[7:5] = 3'h2;
    end
    if (i_valid) begin
      exq.push_back({m, e});
      eaq.push_back(a);
    end
  endtask
  always @(negedge i_core_clk) begin
    if (o_valid === 1'h1) begin
      if (exq.size() == 0) check("valid", 20'h0, 20'h1, 20'h1);
      else begin
        n = exq.pop_front();
        check("decode", n[19:0], {o_reg_sel, o_segment, o_invalid_seg, o_disp_size,
          o_index_byte_present, o_default_seg, o_addr32, o_opcode_ext, o_mem_operand}, n[39:20]);
        check("address", {11'h0, eaq.pop_front()}, {11'h0, o_ea_base, o_ea_index,
          o_ea_scale, o_ea_index_en}, 20'h1ff);
      end
    end
  end
  initial begin
    do_reset(16);
    repeat (300) issue(1'h0, 1'h1);
    repeat (30) issue(1'h1, 1'h1);
    allow_bad = 1'h1;
    repeat (30) issue(1'h0, 1'h1);
    allow_bad = 1'h0;
    repeat (2) issue(1'h0, 1'h0);
    do_reset(3);
    repeat (60) issue(1'h0, 1'h1);
    repeat (2) issue(1'h0, 1'h0);
    check("drain", 20'h0, 20'(exq.size()), 20'hfffff);
    finish_test;
  end
  initial begin
    repeat (2000) @(posedge i_core_clk);
    miscompares++;
    finish_test;
  end
endmodule

// file: sim/ofd_decoder_monitor.sv
// port assertions for the operand field decoder
`timescale 1ns/1ps
module ofd_decoder_monitor (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_valid,
  input wire i_default32,
  input wire i_addrsize_prefix,
  input wire i_fixed_addr,
  input wire [7:0] i_form_byte,
  input wire [2:0] i_segment_sel_wide,
  input wire i_seg_wide,
  input wire o_valid,
  input wire [4:0] o_reg_sel,
  input wire o_mem_operand,
  input wire [2:0] o_segment,
  input wire o_index_byte_present,
  input wire o_addr32,
  input wire o_invalid_seg
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  AST_LATENCY: assert property (i_valid |=> o_valid) else $error("no answer");
  AST_SINGLE: assert property (!i_valid |=> !o_valid) else $error("extra valid");
  AST_HOLD: assert property (!i_valid |=> $stable(o_reg_sel) && $stable(o_segment))
    else $error("output moved");
  AST_WIDE: assert property (i_valid && i_seg_wide && i_segment_sel_wide < 3'h6 |=>
    o_segment == $past(i_segment_sel_wide) && !o_invalid_seg) else $error("wide seg");
  AST_BADSEG: assert property (i_valid && i_seg_wide && i_segment_sel_wide > 3'h5 |=>
    o_invalid_seg && o_segment == 3'h3) else $error("reserved seg");
  AST_SIB: assert property (i_valid && !i_fixed_addr && (i_default32 ^ i_addrsize_prefix) &&
    i_form_byte[2:0] == 3'h4 && i_form_byte[7:6] != 2'h3 |=> o_index_byte_present)
    else $error("index byte");
  AST_REGFORM: assert property (i_valid && i_form_byte[7:6] == 2'h3 |=> !o_mem_operand)
    else $error("reg form");
  AST_A32: assert property (i_valid |=> o_addr32 == ($past(i_default32) ^
    $past(i_addrsize_prefix))) else $error("addr size");
endmodule
bind ofd_decoder ofd_decoder_monitor mon_u (.*);

// file: sim/ofd_fetch_model.sv
// stream model: form byte, index byte and wide segment field
`timescale 1ns/1ps
module ofd_fetch_model (
  input wire i_core_clk,
  input wire i_advance,
  input wire i_allow_bad,
  output reg [7:0] o_form_byte = 8'h00,
  output reg [7:0] o_index_byte = 8'h00,
  output reg [2:0] o_seg_wide = 3'h0
);
  integer seed = 32'h687d3b3d;
  always @(posedge i_core_clk) begin
    if (i_advance) begin
      {o_index_byte, o_form_byte} <= 16'($random(seed));
      o_seg_wide <= i_allow_bad ? 3'h6 + 3'($random(seed) & 1) : 3'($unsigned($random(seed)) % 6);
    end
  end
endmodule
